/* rtl/spl_map.vh */
`ifndef SPL_MAP_VH
`define SPL_MAP_VH
// Functional notes
// RULE1: Unanswered query past error timer is error
// RULE2: Baud codes 0..4 give 2400..38400
// RULE3: Length code 0 eight bits, 1 seven
// RULE4: Parity none, even, odd, none
// RULE5: Modbus stop bits follow parity code
// RULE6: Other protocols: stop code 0 two, 1 one
// RULE7: No-response time 0 off, else seconds
// RULE8: Host re-addresses station within interval
// RULE9: Wait response interval after query end
// RULE10: Port one protocol codes 0, 1, 2
// RULE11: Port two only Modbus or general protocol
// RULE12: Tool uses 8 bits, even, 1 stop; code takes all three from the length, parity and stop fields
// RULE13: Storage select nonvolatile, temporary, copy-then-1
// RULE14: Tool link routes frequency and run sources
// RULE15: Tool link select reads 0 after power-up
// RULE16: Error mode trip, delayed, retry, continue
// RULE17: Errors count only running with link commands
// RULE18: Query restarts count; disabled stops counting
// RULE19: Out-of-range setting codes keep old value

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SPL_A_P1_FRAME 12'h000
`define SPL_A_P1_TIME 12'h004
`define SPL_PORT_STRIDE 12'h008
`define SPL_A_LINK 12'h010
`define SPL_A_STATUS 12'h014
`define SPL_A_DATA 12'h018

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define SPL_F_BAUD 2:0
`define SPL_F_LEN 3
`define SPL_F_PAR 5:4
`define SPL_F_STOP 6
`define SPL_F_PROTO 9:8
`define SPL_F_EMODE 13:12
`define SPL_F_ERRT 9:0
`define SPL_F_NORESP 21:16
`define SPL_F_RESP 30:24
`define SPL_F_STORE 1:0
`define SPL_F_TOOL 3:2
`define SPL_F_BUSL 5:4

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SPL_FRAME_RST 32'h00000000
`define SPL_TIME_RST 32'h00000000
`define SPL_LINK_RST 32'h00000000
`define SPL_BAUD_MAX 3'h4
`define SPL_PROTO_MODBUS 2'h0
`define SPL_PROTO_TOOL 2'h1
`define SPL_PROTO_GEN 2'h2
`define SPL_PAR_EVEN 2'h1
`define SPL_PAR_ODD 2'h2
`define SPL_EMODE_TRIP 2'h0
`define SPL_EMODE_DELAY 2'h1
`define SPL_EMODE_RETRY 2'h2
`define SPL_ERRT_MAX 10'h258
`define SPL_NORESP_MAX 6'h3C
`define SPL_RESP_MAX 7'h64
`define SPL_STORE_NV 2'h0
`define SPL_STORE_TEMP 2'h1
`define SPL_STORE_COPY 2'h2
`define SPL_TOOL_NORMAL 2'h0
`define SPL_BITS8 4'h8
`define SPL_BITS7 4'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPL_CLK_HZ 32'h02625A00
`define SPL_MS_PER_S 32'h000003E8
`define SPL_TICK_MS 32'h0000000A
`define SPL_TICK_CYCLES (`SPL_CLK_HZ / `SPL_MS_PER_S * `SPL_TICK_MS)
`define SPL_TICKS_PER_TENTH 16'h000A
`define SPL_TICKS_PER_SEC 16'h0064
`define SPL_BAUD_R0 32'h00000960
`define SPL_BAUD_R1 32'h000012C0
`define SPL_BAUD_R2 32'h00002580
`define SPL_BAUD_R3 32'h00004B00
`define SPL_BAUD_R4 32'h00009600
`endif

/* rtl/spl_tick.v */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Free-running divider giving one-cycle time base pulses
// ----------------------------------------------------------------
module spl_tick #(
	parameter CYCLES = 400000
) (
	input wire pclk,
	input wire presetn,
	output reg tick_q
);
	reg [31:0] cnt_q;

	// Count up to one full period, pulse once per wrap
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (cnt_q == CYCLES - 1) begin
			cnt_q <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end
endmodule

/* rtl/spl_fifo.v */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Flip-flop FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module spl_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire pclk,
	input wire presetn,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] count
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = (cnt_q != DEPTH);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign count = cnt_q;

	// Storage has no reset; only entries below the count are ever read
	always @(posedge pclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap naturally because depth is a power of two
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

/* rtl/spl_top.v */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`include "spl_map.vh"
module spl_top #(
	parameter TICK_CYCLES = `SPL_TICK_CYCLES,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [1:0] query_ok,
	input wire [1:0] query_end,
	input wire [1:0] query_issued,
	input wire [1:0] answer_rx,
	input wire [1:0] comm_err,
	input wire [1:0] resp_ready,
	input wire drive_running,
	input wire normal_freq_link,
	input wire normal_run_link,
	input wire alarm_clear,
	input wire copy_done,
	input wire store_ready,
	output wire [31:0] baud_div,
	output wire [7:0] data_bits,
	output wire [1:0] parity_en,
	output wire [1:0] parity_odd,
	output wire [1:0] stop_two,
	output wire [3:0] protocol_sel,
	output wire [1:0] resp_start,
	output wire [1:0] trip,
	output wire [1:0] alarm_hold,
	output reg freq_from_link_q,
	output reg run_from_link_q,
	output reg [1:0] bus_link_mode_q,
	output reg copy_start_q,
	output reg store_valid_q,
	output reg [31:0] store_data_q,
	output reg store_nv_q
);
	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	wire tick;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [31:0] fifo_out_data;
	wire [FIFO_AW:0] fifo_count;
	wire fifo_out_nv;
	wire [63:0] frame_all;
	wire [63:0] time_all;
	reg [31:0] link_q;
	wire wr_fire = psel & penable & pwrite & pready;
	wire data_hit = (paddr == `SPL_A_DATA);
	wire recog = drive_running & (freq_from_link_q | run_from_link_q); // [RULE17]
	reg [31:0] rd_mux;
	reg map_hit;

	// Read decode, sampled in the setup cycle so answers come from flops
	always @* begin
		rd_mux = 32'h00000000;
		map_hit = 1'b1;
		case (paddr)
			`SPL_A_P1_FRAME: rd_mux = frame_all[31:0];
			`SPL_A_P1_TIME: rd_mux = time_all[31:0];
			`SPL_A_P1_FRAME + `SPL_PORT_STRIDE: rd_mux = frame_all[63:32];
			`SPL_A_P1_TIME + `SPL_PORT_STRIDE: rd_mux = time_all[63:32];
			`SPL_A_LINK: rd_mux = link_q;
			`SPL_A_STATUS: rd_mux = {14'h0000, run_from_link_q, freq_from_link_q,
				{(7 - FIFO_AW){1'b0}}, fifo_count, 4'h0, alarm_hold, trip};
			`SPL_A_DATA: rd_mux = 32'h00000000;
			default: map_hit = 1'b0;
		endcase
	end

	// Ready rises in the first access cycle; a data push waits for FIFO room
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel & penable & pready) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel) begin
			pready <= ~(pwrite & data_hit) | fifo_in_ready;
			pslverr <= ~map_hit;
			prdata <= pwrite ? 32'h00000000 : rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Link, storage and command source control
	// ----------------------------------------------------------------
	wire link_wr = wr_fire & (paddr == `SPL_A_LINK);
	wire store_ok = (pwdata[`SPL_F_STORE] != 2'h3); // [RULE19]

	// Copy completion returns the select to temporary and beats a write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_q <= `SPL_LINK_RST; // [RULE15]
			copy_start_q <= 1'b0;
			bus_link_mode_q <= 2'h0;
		end else begin
			copy_start_q <= 1'b0;
			if (link_wr) begin
				link_q[`SPL_F_TOOL] <= pwdata[`SPL_F_TOOL];
				link_q[`SPL_F_BUSL] <= pwdata[`SPL_F_BUSL];
				bus_link_mode_q <= pwdata[`SPL_F_BUSL];
				if (store_ok) begin
					link_q[`SPL_F_STORE] <= pwdata[`SPL_F_STORE];
					copy_start_q <= (pwdata[`SPL_F_STORE] == `SPL_STORE_COPY); // [RULE13]
				end
			end
			if (copy_done & (link_q[`SPL_F_STORE] == `SPL_STORE_COPY)) begin
				link_q[`SPL_F_STORE] <= `SPL_STORE_TEMP; // [RULE13]
			end
		end
	end

	// Tool bit 0 takes frequency, bit 1 takes run; else the normal source
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_from_link_q <= 1'b0;
			run_from_link_q <= 1'b0;
		end else begin
			freq_from_link_q <= link_q[2] | normal_freq_link; // [RULE14]
			run_from_link_q <= link_q[3] | normal_run_link; // [RULE14]
		end
	end

	// ----------------------------------------------------------------
	// Data path to storage through the FIFO
	// ----------------------------------------------------------------
	wire fifo_pop = fifo_out_valid & (~store_valid_q | store_ready);

	spl_fifo #(
		.WIDTH(33),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(wr_fire & data_hit),
		.in_ready(fifo_in_ready),
		.in_data({link_q[`SPL_F_STORE] == `SPL_STORE_NV, pwdata}), // [RULE13]
		.out_valid(fifo_out_valid),
		.out_ready(~store_valid_q | store_ready),
		.out_data({fifo_out_nv, fifo_out_data}),
		.count(fifo_count)
	);

	// Output stage keeps store signals on flops; a stall backs up the FIFO
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_valid_q <= 1'b0;
			store_data_q <= 32'h00000000;
			store_nv_q <= 1'b0;
		end else if (~store_valid_q | store_ready) begin
			store_valid_q <= fifo_pop;
			if (fifo_pop) begin
				store_data_q <= fifo_out_data;
				store_nv_q <= fifo_out_nv;
			end
		end
	end

	spl_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick_q(tick)
	);

	// ----------------------------------------------------------------
	// Per-port settings and supervision
	// ----------------------------------------------------------------
	localparam [2:0] ST_RUN = 3'b001;
	localparam [2:0] ST_HOLD = 3'b010;
	localparam [2:0] ST_TRIP = 3'b100;

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			localparam [11:0] A_FR = `SPL_A_P1_FRAME + p * `SPL_PORT_STRIDE;
			localparam [11:0] A_TM = `SPL_A_P1_TIME + p * `SPL_PORT_STRIDE;
			reg [31:0] frame_q;
			reg [31:0] time_q;
			reg [15:0] baud_q;
			reg [3:0] bits_q;
			reg par_en_q;
			reg par_odd_q;
			reg stop_two_q;
			reg [15:0] nr_cnt_q;
			reg [15:0] aw_cnt_q;
			reg aw_q;
			reg [15:0] hold_cnt_q;
			reg [15:0] rd_cnt_q;
			reg rd_wait_q;
			reg rd_allow_q;
			reg resp_q;
			reg [2:0] st_q;
			reg [2:0] st_d;
			reg [31:0] rate;
			wire [1:0] wproto = pwdata[`SPL_F_PROTO];
			wire proto_ok = (wproto == `SPL_PROTO_MODBUS) | (wproto == `SPL_PROTO_GEN) |
				((p == 0) & (wproto == `SPL_PROTO_TOOL)); // [RULE10] [RULE11]
			wire [1:0] emode = frame_q[`SPL_F_EMODE];
			wire [15:0] err_lim = {6'h00, time_q[`SPL_F_ERRT]} * `SPL_TICKS_PER_TENTH;
			wire [15:0] nr_lim = {10'h000, time_q[`SPL_F_NORESP]} * `SPL_TICKS_PER_SEC;
			wire [15:0] rd_lim = {9'h000, time_q[`SPL_F_RESP]};
			wire nr_on = (time_q[`SPL_F_NORESP] != 6'h00); // [RULE7]
			wire nr_exp = nr_on & ~query_ok[p] & (nr_cnt_q >= nr_lim); // [RULE7] [RULE8]
			wire aw_exp = aw_q & ~answer_rx[p] & (aw_cnt_q >= err_lim); // [RULE1]
			wire ev = recog & (comm_err[p] | nr_exp | aw_exp); // [RULE17]
			// A partial first tick is not counted so the wait is never short
			wire rd_done = (rd_lim == 16'h0000) | (rd_cnt_q > rd_lim); // [RULE9]

			// Setting registers; an illegal code leaves its field untouched
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					frame_q <= `SPL_FRAME_RST;
					time_q <= `SPL_TIME_RST;
				end else begin
					if (wr_fire & (paddr == A_FR)) begin
						if (pwdata[`SPL_F_BAUD] <= `SPL_BAUD_MAX) // [RULE19]
							frame_q[`SPL_F_BAUD] <= pwdata[`SPL_F_BAUD];
						if (proto_ok) // [RULE19]
							frame_q[`SPL_F_PROTO] <= wproto;
						frame_q[`SPL_F_LEN] <= pwdata[`SPL_F_LEN];
						frame_q[`SPL_F_PAR] <= pwdata[`SPL_F_PAR];
						frame_q[`SPL_F_STOP] <= pwdata[`SPL_F_STOP];
						frame_q[`SPL_F_EMODE] <= pwdata[`SPL_F_EMODE];
					end
					if (wr_fire & (paddr == A_TM)) begin
						if (pwdata[`SPL_F_ERRT] <= `SPL_ERRT_MAX) // [RULE1] [RULE19]
							time_q[`SPL_F_ERRT] <= pwdata[`SPL_F_ERRT];
						if (pwdata[`SPL_F_NORESP] <= `SPL_NORESP_MAX) // [RULE19]
							time_q[`SPL_F_NORESP] <= pwdata[`SPL_F_NORESP];
						if (pwdata[`SPL_F_RESP] <= `SPL_RESP_MAX) // [RULE9] [RULE19]
							time_q[`SPL_F_RESP] <= pwdata[`SPL_F_RESP];
					end
				end
			end

			// Divisor is clock over line rate; it always fits in 16 bits
			always @* begin
				case (frame_q[`SPL_F_BAUD])
					3'h0: rate = `SPL_CLK_HZ / `SPL_BAUD_R0; // [RULE2]
					3'h1: rate = `SPL_CLK_HZ / `SPL_BAUD_R1;
					3'h2: rate = `SPL_CLK_HZ / `SPL_BAUD_R2;
					3'h3: rate = `SPL_CLK_HZ / `SPL_BAUD_R3;
					default: rate = `SPL_CLK_HZ / `SPL_BAUD_R4;
				endcase
			end

			// Framing outputs; Modbus takes stop bits from the parity code
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					baud_q <= 16'h0000;
					bits_q <= `SPL_BITS8;
					par_en_q <= 1'b0;
					par_odd_q <= 1'b0;
					stop_two_q <= 1'b1;
				end else begin
					baud_q <= rate[15:0]; // [RULE2]
					bits_q <= frame_q[`SPL_F_LEN] ? `SPL_BITS7 : `SPL_BITS8; // [RULE3]
					par_en_q <= (frame_q[`SPL_F_PAR] == `SPL_PAR_EVEN) |
						(frame_q[`SPL_F_PAR] == `SPL_PAR_ODD); // [RULE4]
					par_odd_q <= (frame_q[`SPL_F_PAR] == `SPL_PAR_ODD); // [RULE4]
					if (frame_q[`SPL_F_PROTO] == `SPL_PROTO_MODBUS)
						stop_two_q <= (frame_q[`SPL_F_PAR] == 2'h0); // [RULE5]
					else
						stop_two_q <= ~frame_q[`SPL_F_STOP]; // [RULE6] [RULE12]
				end
			end

			// Interval counters in time-base ticks
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					nr_cnt_q <= 16'h0000;
					aw_cnt_q <= 16'h0000;
					aw_q <= 1'b0;
					rd_cnt_q <= 16'h0000;
					rd_wait_q <= 1'b0;
					rd_allow_q <= 1'b0;
					resp_q <= 1'b0;
				end else begin
					if (~nr_on | query_ok[p] | nr_exp)
						nr_cnt_q <= 16'h0000; // [RULE18]
					else if (tick)
						nr_cnt_q <= nr_cnt_q + 16'h0001; // [RULE18]
					if (query_issued[p]) begin
						aw_q <= 1'b1;
						aw_cnt_q <= 16'h0000;
					end else if (answer_rx[p] | aw_exp) begin
						aw_q <= 1'b0; // [RULE1]
					end else if (aw_q & tick) begin
						aw_cnt_q <= aw_cnt_q + 16'h0001;
					end
					resp_q <= rd_allow_q & resp_ready[p] & ~resp_q;
					if (query_end[p]) begin
						rd_cnt_q <= 16'h0000;
						rd_wait_q <= 1'b1;
						rd_allow_q <= 1'b0;
					end else if (rd_wait_q & rd_done) begin
						rd_wait_q <= 1'b0;
						rd_allow_q <= 1'b1; // [RULE9]
					end else if (rd_wait_q & tick) begin
						rd_cnt_q <= rd_cnt_q + 16'h0001;
					end else if (rd_allow_q & resp_ready[p] & ~resp_q) begin
						rd_allow_q <= 1'b0;
					end
				end
			end

			// Error handling state; a new error outranks an alarm clear
			always @* begin
				st_d = st_q;
				case (st_q)
					ST_RUN: begin
						if (ev & (emode == `SPL_EMODE_TRIP))
							st_d = ST_TRIP; // [RULE16]
						else if (ev & ((emode == `SPL_EMODE_DELAY) | (emode == `SPL_EMODE_RETRY)))
							st_d = ST_HOLD; // [RULE16]
					end
					ST_HOLD: begin
						if ((emode == `SPL_EMODE_RETRY) & query_ok[p] & ~ev)
							st_d = ST_RUN; // [RULE16]
						else if (hold_cnt_q >= err_lim)
							st_d = ST_TRIP; // [RULE16]
					end
					ST_TRIP: begin
						if (alarm_clear & ~ev)
							st_d = ST_RUN;
					end
					default: st_d = ST_RUN;
				endcase
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st_q <= ST_RUN;
					hold_cnt_q <= 16'h0000;
				end else begin
					st_q <= st_d;
					if (st_d != ST_HOLD)
						hold_cnt_q <= 16'h0000;
					else if (tick)
						hold_cnt_q <= hold_cnt_q + 16'h0001;
				end
			end

			assign frame_all[p*32 +: 32] = frame_q;
			assign time_all[p*32 +: 32] = time_q;
			assign baud_div[p*16 +: 16] = baud_q;
			assign data_bits[p*4 +: 4] = bits_q;
			assign parity_en[p] = par_en_q;
			assign parity_odd[p] = par_odd_q;
			assign stop_two[p] = stop_two_q;
			assign protocol_sel[p*2 +: 2] = frame_q[`SPL_F_PROTO];
			assign resp_start[p] = resp_q;
			assign trip[p] = st_q[2];
			assign alarm_hold[p] = st_q[1];
		end
	endgenerate
endmodule

/* dv/spl_monitor.sv */
`timescale 1ns/100ps
`include "spl_map.vh"
// ----------------------------------------------------------------
// Port-level checks of the serial link configuration block
// ----------------------------------------------------------------
module spl_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [1:0] resp_ready,
	input wire normal_freq_link,
	input wire store_ready,
	input wire [31:0] baud_div,
	input wire [7:0] data_bits,
	input wire [1:0] parity_en,
	input wire [1:0] parity_odd,
	input wire [1:0] stop_two,
	input wire [3:0] protocol_sel,
	input wire [1:0] resp_start,
	input wire freq_from_link_q,
	input wire copy_start_q,
	input wire store_valid_q,
	input wire [31:0] store_data_q,
	input wire store_nv_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers only inside an access phase; unmapped places are refused
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_unmapped_refused: assert property (psel && penable && pready && paddr > `SPL_A_DATA
		|-> pslverr && prdata == 32'h00000000) else $error("unmapped access not refused");
	// Framing outputs only ever show legal settings
	a_baud_legal: assert property ($past(presetn) |-> baud_div[15:0] inside
		{16'h411A, 16'h208D, 16'h1046, 16'h0823, 16'h0411}) else $error("bad divider");
	a_bits_legal: assert property ((data_bits[3:0] == 4'h8 || data_bits[3:0] == 4'h7)
		&& (data_bits[7:4] == 4'h8 || data_bits[7:4] == 4'h7)) else $error("bad length");
	a_odd_needs_parity: assert property (parity_odd[0] |-> parity_en[0])
		else $error("odd parity without parity");
	a_modbus_stop_one: assert property (protocol_sel[1:0] == 2'h0 && parity_en[0]
		|-> !stop_two[0]) else $error("modbus with parity must use one stop bit");
	// A response never starts without a prepared answer
	a_resp_needs_ready: assert property ($rose(resp_start[0]) |-> $past(resp_ready[0]))
		else $error("response started while not prepared");
	// Copy pulse comes only from a write of the copy code, and lasts one cycle
	a_copy_cause: assert property (copy_start_q |-> $past(psel && penable && pready
		&& pwrite && paddr == `SPL_A_LINK && pwdata[1:0] == 2'h2)) else $error("stray copy");
	a_copy_pulse: assert property (copy_start_q |=> !copy_start_q)
		else $error("copy pulse too long");
	a_link_freq: assert property ($past(normal_freq_link) && $past(presetn)
		|-> freq_from_link_q) else $error("normal frequency source lost");
	// A word offered to storage stays put until it is taken
	a_store_hold: assert property (store_valid_q && !store_ready |=> store_valid_q
		&& $stable(store_data_q) && $stable(store_nv_q)) else $error("store word dropped");
endmodule
bind spl_top spl_monitor i_mon (.*);

/* dv/spl_store_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Storage side: takes words at a varying pace, answers copy requests
// ----------------------------------------------------------------
module spl_store_model (
	input wire pclk,
	input wire presetn,
	input wire hold,
	input wire copy_start_q,
	output reg store_ready,
	output reg copy_done
);
	reg [1:0] pace_q;
	reg [2:0] copy_cnt_q;
	// Ready two cycles in three, so the stage meets both quick and slow takes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pace_q <= 2'h0;
			store_ready <= 1'h0;
			copy_cnt_q <= 3'h0;
			copy_done <= 1'h0;
		end else begin
			pace_q <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
			store_ready <= !hold && pace_q != 2'h0;
			copy_cnt_q <= copy_start_q ? 3'h5 : (copy_cnt_q != 3'h0) ? copy_cnt_q - 3'h1 : 3'h0;
			copy_done <= (copy_cnt_q == 3'h1); // Nonvolatile copy takes a few cycles
		end
	end
endmodule

/* dv/serial_port_link_config_bench.sv */
`timescale 1ns/100ps
`include "spl_map.vh"
module serial_port_link_config_bench;
	reg pclk = 1'h0;
	reg presetn = 1'h0;
	reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0, hold = 1'h0, alarm_clear = 1'h0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000, rnd = 32'h0000003F;
	reg [1:0] query_ok = 2'h0, query_end = 2'h0, query_issued = 2'h0;
	reg [1:0] answer_rx = 2'h0, comm_err = 2'h0, resp_ready = 2'h0;
	reg drive_running = 1'h0, normal_freq_link = 1'h0, normal_run_link = 1'h0;
	wire [31:0] prdata, baud_div, store_data_q;
	wire [7:0] data_bits;
	wire [3:0] protocol_sel;
	wire [1:0] parity_en, parity_odd, stop_two, resp_start, trip, alarm_hold, bus_link_mode_q;
	wire pready, pslverr, copy_done, store_ready, freq_from_link_q, run_from_link_q;
	wire copy_start_q, store_valid_q, store_nv_q;
	reg [31:0] exp_rd[$];
	reg [32:0] exp_st[$];
	integer fails = 0, checks = 0, i, n;
	spl_top #(.TICK_CYCLES(40)) i_dut (.*);
	spl_store_model i_sink (.*);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	always #12.5 pclk = ~pclk;
	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xs = y ^ (y << 5);
	endfunction
	function [15:0] bdiv(input integer c);
		bdiv = 32'h02625A00 / (32'h00000960 << c); // Clock over line rate, truncated
	endfunction
	task automatic chk(input [31:0] got, input [31:0] want);
		checks = checks + 1;
		if (got !== want) begin
			fails = fails + 1;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task print_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge pclk);
	endtask
	// One APB transfer; a stalled slave is waited for under a bound
	task apb(input w, input [11:0] a, input [31:0] d);
		integer k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && k < 400) begin
			@(posedge pclk);
			k = k + 1;
		end
		chk(k < 400, 32'h1);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	// Writes wait two edges so registered outputs have settled
	task wr(input [11:0] a, input [31:0] d);
		apb(1'h1, a, d);
		cyc(2);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		exp_rd.push_back(e);
		apb(1'h0, a, 32'h00000000);
	endtask
	task put(input nv);
		rnd = xs(rnd);
		exp_st.push_back({nv, rnd});
		wr(`SPL_A_DATA, rnd);
	endtask
	// Port one event pulses, query_end first
	task ev(input [4:0] s);
		{query_end[0], answer_rx[0], query_issued[0], query_ok[0], comm_err[0]} <= s;
		@(posedge pclk);
		{query_end[0], answer_rx[0], query_issued[0], query_ok[0], comm_err[0]} <= 5'h00;
		@(posedge pclk);
	endtask
	task clr;
		alarm_clear <= 1'h1;
		cyc(2);
		alarm_clear <= 1'h0;
		cyc(2);
	endtask
	// Watchers take the oldest note whenever a result appears
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'h1 && !pwrite && exp_rd.size() != 0)
			chk(prdata, exp_rd.pop_front());
		if (store_valid_q === 1'h1 && store_ready === 1'h1 && exp_st.size() != 0)
			chk({store_nv_q, store_data_q}, exp_st.pop_front());
	end
	initial begin
		cyc(60000);
		fails = fails + 1;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict;
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		cyc(3);
		presetn <= 1'h1;
		rd(`SPL_A_LINK, 32'h00000000);
		rd(12'h01C, 32'h00000000);
		chk({24'h0, data_bits, 6'h0, stop_two}, 32'h00008803);
		chk(baud_div, 32'h411A411A);
		// Nonvolatile target, then copy returns the select to temporary
		for (i = 0; i < 3; i = i + 1) put(1'h1);
		wr(`SPL_A_LINK, 32'h00000002);
		cyc(10);
		rd(`SPL_A_LINK, 32'h00000001);
		wr(`SPL_A_LINK, 32'h00000003);
		rd(`SPL_A_LINK, 32'h00000001);
		// Every baud code, then an illegal one that must be ignored
		for (i = 0; i < 5; i = i + 1) begin
			wr(`SPL_A_P1_FRAME, i);
			chk(baud_div, {16'h411A, bdiv(i)});
		end
		wr(`SPL_A_P1_FRAME, 32'h00000005);
		rd(`SPL_A_P1_FRAME, 32'h00000004);
		wr(`SPL_A_P1_FRAME, 32'h00000008);
		chk(data_bits, 32'h00000087);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`SPL_A_P1_FRAME, i << 4);
			chk({parity_en[0], parity_odd[0], stop_two[0]}, (12'h1A1 >> (i * 3)) & 3'h7);
		end
		for (i = 0; i < 2; i = i + 1) begin
			wr(`SPL_A_P1_FRAME, 32'h00000210 | (i << 6));
			chk(stop_two[0], !i);
		end
		// Protocol codes; the tool frames 8 bits, even parity, one stop
		for (i = 0; i < 3; i = i + 1) begin
			wr(`SPL_A_P1_FRAME, (i == 1) ? 32'h00000150 : (i << 8));
			chk(protocol_sel[1:0], i);
		end
		wr(`SPL_A_P1_FRAME + `SPL_PORT_STRIDE, 32'h00000200);
		wr(`SPL_A_P1_FRAME + `SPL_PORT_STRIDE, 32'h00000100);
		rd(`SPL_A_P1_FRAME + `SPL_PORT_STRIDE, 32'h00000200);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`SPL_A_LINK, (i << 2) | 32'h1);
			chk({freq_from_link_q, run_from_link_q}, {i[0], i[1]});
		end
		normal_freq_link <= 1'h1;
		normal_run_link <= 1'h1;
		wr(`SPL_A_LINK, 32'h00000001);
		chk({freq_from_link_q, run_from_link_q}, 32'h3);
		normal_freq_link <= 1'h0;
		normal_run_link <= 1'h0;
		// Error modes with a 0.1 s timer (10 ticks of 40 cycles)
		drive_running <= 1'h1;
		wr(`SPL_A_LINK, 32'h0000000D);
		wr(`SPL_A_P1_TIME, 32'h00000001);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`SPL_A_P1_FRAME, i << 12);
			ev(5'h01);
			cyc(3);
			chk({alarm_hold[0], trip[0]}, {i == 1 || i == 2, i == 0});
			if (i == 2) ev(5'h02);
			cyc(300);
			chk(trip[0], i == 0);
			cyc(200);
			chk({alarm_hold[0], trip[0]}, (i < 2) ? 2'h1 : 2'h0);
			clr;
		end
		wr(`SPL_A_P1_FRAME, 32'h00000000);
		drive_running <= 1'h0;
		ev(5'h01);
		cyc(3);
		chk(trip[0], 32'h0);
		drive_running <= 1'h1;
		// Unanswered query counts as an error once the timer runs out
		ev(5'h04);
		cyc(100);
		ev(5'h08);
		cyc(500);
		chk(trip[0], 32'h0);
		ev(5'h04);
		cyc(300);
		chk(trip[0], 32'h0);
		cyc(200);
		chk(trip[0], 32'h1);
		clr;
		// One second of silence trips; queries inside it keep the link alive
		wr(`SPL_A_P1_TIME, 32'h00010001);
		ev(5'h02);
		for (i = 0; i < 2; i = i + 1) begin
			cyc(3000);
			ev(5'h02);
			chk(trip[0], 32'h0);
		end
		cyc(3800);
		chk(trip[0], 32'h0);
		cyc(400);
		chk(trip[0], 32'h1);
		wr(`SPL_A_P1_TIME, 32'h00000001);
		clr;
		cyc(4500);
		chk(trip[0], 32'h0);
		// Response delay of two hundredths, then of zero
		resp_ready <= 2'h1;
		for (i = 0; i < 2; i = i + 1) begin
			wr(`SPL_A_P1_TIME, (i == 0) ? 32'h02000000 : 32'h00000000);
			ev(5'h10);
			n = 0;
			while (resp_start[0] !== 1'h1 && n < 400) begin
				@(posedge pclk);
				n = n + 1;
			end
			chk((i == 0) ? (n >= 75 && n <= 130) : (n <= 5), 32'h1);
		end
		// Fill the buffer with storage stalled, then drain it
		hold <= 1'h1;
		for (i = 0; i < 17; i = i + 1) put(1'h0);
		rd(`SPL_A_STATUS, 32'h00031000);
		fork
			put(1'h0);
			begin
				cyc(20);
				chk(pready, 32'h0);
				hold <= 1'h0;
			end
		join
		n = 0;
		while (exp_st.size() != 0 && n < 500) begin
			cyc(1);
			n = n + 1;
		end
		chk(exp_st.size(), 32'h0);
		rd(`SPL_A_STATUS, 32'h00030000);
		print_verdict;
	end
endmodule
